/* File: rtl/fmsp_pkg.sv */
// Purpose: Shared constants and types of the four-mode serial port.
// Assumes: The system clock is the oscillator clock.
// Notes: Register addresses are byte addresses of the special function space.
`default_nettype none

package fmsp_pkg;

  // ==========================================================================
  // Register map
  typedef logic [7:0] fmsp_byte_t;
  localparam fmsp_byte_t FMSP_CTRL_ADDR = 8'h98;
  localparam fmsp_byte_t FMSP_DATA_ADDR = 8'h99;
  localparam fmsp_byte_t FMSP_CTRL_RESET = 8'h00;

  // ==========================================================================
  // Control register fields
  localparam logic [2:0] FMSP_BIT_MODE_HI = 3'h7;
  localparam logic [2:0] FMSP_BIT_MODE_LO = 3'h6;
  localparam logic [2:0] FMSP_BIT_FILTER = 3'h5;
  localparam logic [2:0] FMSP_BIT_RX_EN = 3'h4;
  localparam logic [2:0] FMSP_BIT_TX9 = 3'h3;
  localparam logic [2:0] FMSP_BIT_RX9 = 3'h2;
  localparam logic [2:0] FMSP_BIT_TX_DONE = 3'h1;
  localparam logic [2:0] FMSP_BIT_RX_DONE = 3'h0;

  // ==========================================================================
  // Timing
  localparam int FMSP_M0_DIV = 12;
  localparam int FMSP_M2_SLOW_DIV = 64;
  localparam int FMSP_M2_FAST_DIV = 32;
  localparam int FMSP_OVERSAMPLE = 16;
  localparam logic [2:0] FMSP_M0_HALF_LAST = 3'(FMSP_M0_DIV / 2 - 1);
  localparam logic [1:0] FMSP_M2_SLOW_LAST = 2'(FMSP_M2_SLOW_DIV / FMSP_OVERSAMPLE - 1);
  localparam logic [1:0] FMSP_M2_FAST_LAST = 2'(FMSP_M2_FAST_DIV / FMSP_OVERSAMPLE - 1);
  localparam logic [3:0] FMSP_SUB_LAST = 4'(FMSP_OVERSAMPLE - 1);
  localparam logic [3:0] FMSP_SUB_VOTE_A = 4'h7;
  localparam logic [3:0] FMSP_SUB_VOTE_B = 4'h8;
  localparam logic [3:0] FMSP_SUB_SAMPLE = 4'h9;
  localparam logic [3:0] FMSP_M0_PHASE_LAST = 4'hf;
  localparam logic [2:0] FMSP_BIT_LAST = 3'h7;
  localparam int FMSP_FIFO_DEPTH = 4;

  // ==========================================================================
  // Modes and states
  typedef enum logic [1:0] {
    FMSP_MODE_SHIFT = 2'b00,
    FMSP_MODE_UART8 = 2'b01,
    FMSP_MODE_UART9_FIXED = 2'b10,
    FMSP_MODE_UART9_VAR = 2'b11
  } fmsp_mode_t;

  typedef enum logic [2:0] {
    FMSP_FR_IDLE = 3'b000,
    FMSP_FR_START = 3'b001,
    FMSP_FR_DATA = 3'b011,
    FMSP_FR_NINTH = 3'b010,
    FMSP_FR_STOP = 3'b110
  } fmsp_frame_t;

  typedef enum logic {
    FMSP_M0_IDLE = 1'b0,
    FMSP_M0_SHIFT = 1'b1
  } fmsp_m0_t;

endpackage : fmsp_pkg

`default_nettype wire

/* File: rtl/fmsp_stream_if.sv */
// Purpose: Valid/ready word carrier between the serial port and its buffer.
// Assumes: One clock domain.
// Notes: A word moves when valid and ready are both high at a clock edge.
`default_nettype none

interface fmsp_stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : fmsp_stream_if

`default_nettype wire

/* File: rtl/fmsp_fifo.sv */
// Purpose: Small first-in first-out buffer with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Head word is shown combinationally on the drain side.
`default_nettype none

module fmsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  fmsp_stream_if.snk fill_side,
  fmsp_stream_if.src drain_side
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign fill_side.ready = (count_reg != (AW + 1)'(DEPTH));
  assign drain_side.valid = (count_reg != '0);
  assign drain_side.data = mem[rptr_reg];
  assign push = fill_side.valid && fill_side.ready;
  assign pop = drain_side.valid && drain_side.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= fill_side.data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule : fmsp_fifo

`default_nettype wire

/* File: rtl/fmsp_serial_port.sv */
// Purpose: Four-mode serial port with shift-register and UART frames.
// Assumes: clk is the oscillator; timer overflow pulses share clk.
// Notes: Transmit bytes pass a four-word buffer before the shifter.
// Contract
// - Mode 0 shifts 8 bits LSB first, clock out
// - Mode 0 shift clock is oscillator over twelve
// - Mode 1 frame: start, 8 data, stop
// - Mode 1 receive stores stop bit as ninth
// - Mode 2 frame: start, 8 data, ninth, stop
// - Transmit ninth bit comes from control field
// - 11-bit receive stores ninth, ignores stop
// - Mode 2 rate is oscillator over 32 or 64
// - Mode 3 equals mode 2 with timer rate
// - Data buffer write starts a transmission
// - Mode 0 receive starts when flag clear, enabled
// - Modes 1-3 receive on start bit when enabled
// - Control register field layout, mode select encoding
// - Done flags act as interrupt requests
// - Control resets to zero, bit writable
// - Separate transmit and receive timer source selects
// - Timer modes divide overflow rate by sixteen
`default_nettype none

module fmsp_serial_port (
  input wire logic clk,
  input wire logic rst,
  input wire fmsp_pkg::fmsp_byte_t sfr_addr,
  input wire fmsp_pkg::fmsp_byte_t sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output fmsp_pkg::fmsp_byte_t sfr_rdata,
  input wire fmsp_pkg::fmsp_byte_t sfr_bit_addr,
  input wire logic sfr_bit_wdata,
  input wire logic sfr_bit_wr,
  input wire logic sfr_bit_rd,
  output logic sfr_bit_rdata,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic tx_baud_src_sel,
  input wire logic rx_baud_src_sel,
  input wire logic rate_double,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  output logic tx_buf_ready,
  output logic tx_done_flag,
  output logic rx_done_flag,
  output logic serial_irq
);
  import fmsp_pkg::*;

  // ==========================================================================
  // Declarations
  fmsp_byte_t ctrl_reg;
  fmsp_byte_t ctrl_next;
  fmsp_byte_t rx_data_reg;
  fmsp_mode_t mode;
  logic ren;
  logic filter;
  logic ctrl_bit_hit;
  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic rxd_prev_reg;
  logic [2:0] half_cnt_reg;
  logic half_tick;
  logic [1:0] m2_cnt_reg;
  logic m2_tick;
  logic tx_tick;
  logic rx_tick;
  fmsp_frame_t tx_state_reg;
  logic [3:0] tx_sub_reg;
  logic [2:0] tx_bitn_reg;
  fmsp_byte_t tx_shift_reg;
  logic tx_bit9_reg;
  logic tx_line_reg;
  logic tx_bit_end;
  logic tx_stop_enter;
  logic tx_take;
  fmsp_frame_t rx_state_reg;
  logic [3:0] rx_sub_reg;
  logic [2:0] rx_bitn_reg;
  fmsp_byte_t rx_shift_reg;
  logic rx_bit9_reg;
  logic [1:0] vote_reg;
  logic rx_bit_val;
  logic rx_sample;
  logic rx_stop_pt;
  logic rx_accept;
  fmsp_m0_t m0_state_reg;
  logic m0_dir_tx_reg;
  logic [3:0] m0_phase_reg;
  fmsp_byte_t m0_shift_reg;
  logic m0_clk_reg;
  logic m0_end;
  logic m0_rx_start;
  logic m0_rx_accept;
  logic ti_set;
  logic ri_set;

  fmsp_stream_if #(.WIDTH(8)) tx_fill_if ();
  fmsp_stream_if #(.WIDTH(8)) tx_drain_if ();

  assign mode = fmsp_mode_t'(ctrl_reg[FMSP_BIT_MODE_HI -: 2]);
  assign ren = ctrl_reg[FMSP_BIT_RX_EN];
  assign filter = ctrl_reg[FMSP_BIT_FILTER];

  // ==========================================================================
  // Transmit buffer
  assign tx_fill_if.valid = sfr_wr && (sfr_addr == FMSP_DATA_ADDR);
  assign tx_fill_if.data = sfr_wdata;
  assign tx_buf_ready = tx_fill_if.ready;
  assign tx_drain_if.ready = tx_take;

  fmsp_fifo #(.WIDTH(8), .DEPTH(FMSP_FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst(rst),
    .fill_side(tx_fill_if),
    .drain_side(tx_drain_if)
  );

  // Mode 0 waits for a half-phase boundary so the clock keeps its shape
  assign tx_take = tx_drain_if.valid &&
      ((mode == FMSP_MODE_SHIFT) ? (m0_state_reg == FMSP_M0_IDLE && half_tick)
                                 : (tx_state_reg == FMSP_FR_IDLE));

  // ==========================================================================
  // Control register
  assign ctrl_bit_hit = sfr_bit_wr && (sfr_bit_addr[7:3] == FMSP_CTRL_ADDR[7:3]);

  always_comb begin
    ctrl_next = ctrl_reg;
    if (sfr_wr && sfr_addr == FMSP_CTRL_ADDR) begin
      ctrl_next = sfr_wdata;
    end
    if (ctrl_bit_hit) begin
      ctrl_next[sfr_bit_addr[2:0]] = sfr_bit_wdata;
    end
    if (rx_accept && !m0_rx_accept) begin
      // Mode 1 keeps the stop bit, 11-bit modes keep the ninth bit
      ctrl_next[FMSP_BIT_RX9] = (mode == FMSP_MODE_UART8) ? rx_bit_val : rx_bit9_reg;
    end
    // Hardware set wins over a software clear in the same cycle
    if (ti_set) begin
      ctrl_next[FMSP_BIT_TX_DONE] = 1'b1;
    end
    if (ri_set) begin
      ctrl_next[FMSP_BIT_RX_DONE] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= FMSP_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign tx_done_flag = ctrl_reg[FMSP_BIT_TX_DONE];
  assign rx_done_flag = ctrl_reg[FMSP_BIT_RX_DONE];
  assign serial_irq = tx_done_flag || rx_done_flag;

  // ==========================================================================
  // Register reads
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= '0;
      sfr_bit_rdata <= 1'b0;
    end else begin
      sfr_rdata <= '0;
      if (sfr_rd && sfr_addr == FMSP_CTRL_ADDR) begin
        sfr_rdata <= ctrl_reg;
      end else if (sfr_rd && sfr_addr == FMSP_DATA_ADDR) begin
        sfr_rdata <= rx_data_reg;
      end
      sfr_bit_rdata <= sfr_bit_rd && (sfr_bit_addr[7:3] == FMSP_CTRL_ADDR[7:3]) &&
          ctrl_reg[sfr_bit_addr[2:0]];
    end
  end

  // ==========================================================================
  // Receive pin synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end else begin
      rxd_meta_reg <= rxd_in;
      rxd_sync_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_sync_reg;
    end
  end

  // ==========================================================================
  // Rate enables
  assign half_tick = (half_cnt_reg == FMSP_M0_HALF_LAST);
  assign m2_tick = (m2_cnt_reg == (rate_double ? FMSP_M2_FAST_LAST : FMSP_M2_SLOW_LAST));

  always_ff @(posedge clk) begin
    if (rst) begin
      half_cnt_reg <= '0;
    end else if (half_tick) begin
      half_cnt_reg <= '0;
    end else begin
      half_cnt_reg <= half_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || m2_tick) begin
      m2_cnt_reg <= '0;
    end else begin
      m2_cnt_reg <= m2_cnt_reg + 1'b1;
    end
  end

  // Sixteen ticks per bit in every frame mode
  assign tx_tick = (mode == FMSP_MODE_UART9_FIXED) ? m2_tick :
      (tx_baud_src_sel ? timer2_ovf : timer1_ovf);
  assign rx_tick = (mode == FMSP_MODE_UART9_FIXED) ? m2_tick :
      (rx_baud_src_sel ? timer2_ovf : timer1_ovf);

  // ==========================================================================
  // Frame transmitter
  assign tx_bit_end = tx_tick && (tx_sub_reg == FMSP_SUB_LAST);
  assign tx_stop_enter = tx_bit_end && (tx_state_reg == FMSP_FR_NINTH ||
      (tx_state_reg == FMSP_FR_DATA && tx_bitn_reg == FMSP_BIT_LAST &&
       mode == FMSP_MODE_UART8));

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state_reg <= FMSP_FR_IDLE;
      tx_sub_reg <= '0;
      tx_bitn_reg <= '0;
      tx_shift_reg <= '0;
      tx_bit9_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end else if (tx_state_reg == FMSP_FR_IDLE) begin
      tx_line_reg <= 1'b1;
      if (tx_take && mode != FMSP_MODE_SHIFT) begin
        tx_state_reg <= FMSP_FR_START;
        tx_sub_reg <= '0;
        tx_shift_reg <= tx_drain_if.data;
        tx_bit9_reg <= ctrl_reg[FMSP_BIT_TX9];
        tx_line_reg <= 1'b0;
      end
    end else if (tx_tick) begin
      tx_sub_reg <= tx_sub_reg + 1'b1;
      if (tx_bit_end) begin
        unique case (tx_state_reg)
          FMSP_FR_START: begin
            tx_state_reg <= FMSP_FR_DATA;
            tx_bitn_reg <= '0;
            tx_line_reg <= tx_shift_reg[0];
          end
          FMSP_FR_DATA: begin
            if (tx_bitn_reg != FMSP_BIT_LAST) begin
              tx_bitn_reg <= tx_bitn_reg + 1'b1;
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_line_reg <= tx_shift_reg[1];
            end else if (mode == FMSP_MODE_UART8) begin
              tx_state_reg <= FMSP_FR_STOP;
              tx_line_reg <= 1'b1;
            end else begin
              tx_state_reg <= FMSP_FR_NINTH;
              tx_line_reg <= tx_bit9_reg;
            end
          end
          FMSP_FR_NINTH: begin
            tx_state_reg <= FMSP_FR_STOP;
            tx_line_reg <= 1'b1;
          end
          FMSP_FR_STOP: begin
            tx_state_reg <= FMSP_FR_IDLE;
          end
          default: begin
            tx_state_reg <= FMSP_FR_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Frame receiver
  assign rx_sample = rx_tick && (rx_sub_reg == FMSP_SUB_SAMPLE);
  // Majority of three samples around mid-bit
  assign rx_bit_val = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & rxd_sync_reg) |
      (vote_reg[1] & rxd_sync_reg);
  assign rx_stop_pt = rx_sample && (rx_state_reg == FMSP_FR_STOP);
  assign rx_accept = (rx_stop_pt && !rx_done_flag &&
      (!filter || ((mode == FMSP_MODE_UART8) ? rx_bit_val : rx_bit9_reg))) ||
      m0_rx_accept;

  always_ff @(posedge clk) begin
    if (rst) begin
      vote_reg <= 2'b11;
    end else if (rx_tick && rx_sub_reg == FMSP_SUB_VOTE_A) begin
      vote_reg[0] <= rxd_sync_reg;
    end else if (rx_tick && rx_sub_reg == FMSP_SUB_VOTE_B) begin
      vote_reg[1] <= rxd_sync_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state_reg <= FMSP_FR_IDLE;
      rx_sub_reg <= '0;
      rx_bitn_reg <= '0;
      rx_shift_reg <= '0;
      rx_bit9_reg <= 1'b0;
    end else if (rx_state_reg == FMSP_FR_IDLE) begin
      if (mode != FMSP_MODE_SHIFT && ren && rxd_prev_reg && !rxd_sync_reg) begin
        rx_state_reg <= FMSP_FR_START;
        rx_sub_reg <= '0;
      end
    end else if (rx_tick) begin
      rx_sub_reg <= rx_sub_reg + 1'b1;
      unique case (rx_state_reg)
        FMSP_FR_START: begin
          if (rx_sample && rx_bit_val) begin
            rx_state_reg <= FMSP_FR_IDLE;
          end else if (rx_sub_reg == FMSP_SUB_LAST) begin
            rx_state_reg <= FMSP_FR_DATA;
            rx_bitn_reg <= '0;
          end
        end
        FMSP_FR_DATA: begin
          if (rx_sample) begin
            rx_shift_reg <= {rx_bit_val, rx_shift_reg[7:1]};
          end
          if (rx_sub_reg == FMSP_SUB_LAST) begin
            rx_bitn_reg <= rx_bitn_reg + 1'b1;
            if (rx_bitn_reg == FMSP_BIT_LAST) begin
              rx_state_reg <= (mode == FMSP_MODE_UART8) ? FMSP_FR_STOP : FMSP_FR_NINTH;
            end
          end
        end
        FMSP_FR_NINTH: begin
          if (rx_sample) begin
            rx_bit9_reg <= rx_bit_val;
          end
          if (rx_sub_reg == FMSP_SUB_LAST) begin
            rx_state_reg <= FMSP_FR_STOP;
          end
        end
        FMSP_FR_STOP: begin
          if (rx_sample) begin
            rx_state_reg <= FMSP_FR_IDLE;
          end
        end
        default: begin
          rx_state_reg <= FMSP_FR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Mode 0 shift engine
  assign m0_end = (m0_state_reg == FMSP_M0_SHIFT) && half_tick &&
      (m0_phase_reg == FMSP_M0_PHASE_LAST);
  assign m0_rx_start = (mode == FMSP_MODE_SHIFT) && (m0_state_reg == FMSP_M0_IDLE) &&
      half_tick && !tx_drain_if.valid && ren && !rx_done_flag;
  assign m0_rx_accept = m0_end && !m0_dir_tx_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      m0_state_reg <= FMSP_M0_IDLE;
      m0_dir_tx_reg <= 1'b0;
      m0_phase_reg <= '0;
      m0_shift_reg <= '0;
      m0_clk_reg <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
    end else if (m0_state_reg == FMSP_M0_IDLE) begin
      m0_phase_reg <= '0;
      if (tx_take && mode == FMSP_MODE_SHIFT) begin
        m0_state_reg <= FMSP_M0_SHIFT;
        m0_dir_tx_reg <= 1'b1;
        m0_shift_reg <= tx_drain_if.data;
        m0_clk_reg <= 1'b0;
        rxd_out <= tx_drain_if.data[0];
        rxd_oe <= 1'b1;
      end else if (m0_rx_start) begin
        m0_state_reg <= FMSP_M0_SHIFT;
        m0_dir_tx_reg <= 1'b0;
        m0_clk_reg <= 1'b0;
        rxd_oe <= 1'b0;
      end
    end else if (half_tick) begin
      m0_phase_reg <= m0_phase_reg + 1'b1;
      if (!m0_phase_reg[0]) begin
        m0_clk_reg <= 1'b1;
        if (!m0_dir_tx_reg) begin
          m0_shift_reg <= {rxd_sync_reg, m0_shift_reg[7:1]};
        end
      end else if (m0_end) begin
        m0_state_reg <= FMSP_M0_IDLE;
        m0_clk_reg <= 1'b1;
        rxd_oe <= 1'b0;
        rxd_out <= 1'b1;
      end else begin
        m0_clk_reg <= 1'b0;
        if (m0_dir_tx_reg) begin
          m0_shift_reg <= {1'b0, m0_shift_reg[7:1]};
          rxd_out <= m0_shift_reg[1];
        end
      end
    end
  end

  assign txd_out = (mode == FMSP_MODE_SHIFT) ? m0_clk_reg : tx_line_reg;

  // ==========================================================================
  // Received data and flag events
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data_reg <= '0;
    end else if (m0_rx_accept) begin
      rx_data_reg <= m0_shift_reg;
    end else if (rx_accept) begin
      rx_data_reg <= rx_shift_reg;
    end
  end

  assign ti_set = tx_stop_enter || (m0_end && m0_dir_tx_reg);
  assign ri_set = rx_accept;

endmodule : fmsp_serial_port

`default_nettype wire

/* File: testbench/fmsp_chk.sv */
// Purpose: Port checker of the serial port
// Assumes: One clock, synchronous rst
// Notes: Bound into every serial port
`default_nettype none
module fmsp_chk (
  input wire logic clk,
  input wire logic rst,
  input wire fmsp_pkg::fmsp_byte_t sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire fmsp_pkg::fmsp_byte_t sfr_rdata,
  input wire fmsp_pkg::fmsp_byte_t sfr_bit_addr,
  input wire logic sfr_bit_wr,
  input wire logic sfr_bit_rd,
  input wire logic sfr_bit_rdata,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out,
  input wire logic tx_done_flag,
  input wire logic rx_done_flag,
  input wire logic serial_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  import fmsp_pkg::*;
  wire logic ctrl_wr = sfr_wr && sfr_addr == FMSP_CTRL_ADDR;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // Assertions
  a_irq_or: assert property (serial_irq == (tx_done_flag | rx_done_flag))
    else $error("irq differs from flags");
  a_rst_quiet: assert property ($fell(rst) |-> !tx_done_flag && !rx_done_flag && txd_out && !rxd_oe)
    else $error("port not idle after reset");
  a_rd_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data without read");
  a_ctrl_read: assert property (sfr_rd && sfr_addr == FMSP_CTRL_ADDR |=>
    sfr_rdata[1:0] == {$past(tx_done_flag), $past(rx_done_flag)})
    else $error("flags read wrong");
  a_bit_read: assert property (sfr_bit_rd && sfr_bit_addr == FMSP_CTRL_ADDR |=>
    sfr_bit_rdata == $past(rx_done_flag))
    else $error("bit read wrong");
  a_rx_clear: assert property ($fell(rx_done_flag) |->
    $past(ctrl_wr || sfr_bit_wr && sfr_bit_addr == FMSP_CTRL_ADDR))
    else $error("rx flag cleared by hardware");
  a_tx_clear: assert property ($fell(tx_done_flag) |->
    $past(ctrl_wr || sfr_bit_wr && sfr_bit_addr == 8'h99))
    else $error("tx flag cleared by hardware");
  a_tx_set_line: assert property ($rose(tx_done_flag) |-> txd_out)
    else $error("tx flag set with line low");
  a_idle_data: assert property (!rxd_oe |-> rxd_out)
    else $error("data pin value while released");
  a_m0_clock: assert property ($fell(txd_out) && rxd_oe |=> !txd_out [*5] ##1 txd_out)
    else $error("shift clock low phase not 6");
  c_tx_frame: cover property ($rose(tx_done_flag));
  c_rx_frame: cover property ($rose(rx_done_flag));
  c_m0_drive: cover property ($rose(rxd_oe));
endmodule : fmsp_chk

bind fmsp_serial_port fmsp_chk u_chk (
  .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .sfr_bit_addr(sfr_bit_addr), .sfr_bit_wr(sfr_bit_wr),
  .sfr_bit_rd(sfr_bit_rd), .sfr_bit_rdata(sfr_bit_rdata), .rxd_out(rxd_out),
  .rxd_oe(rxd_oe), .txd_out(txd_out), .tx_done_flag(tx_done_flag),
  .rx_done_flag(rx_done_flag), .serial_irq(serial_irq)
);
`default_nettype wire

/* File: testbench/fmsp_peer.sv */
// Purpose: Remote transceiver on the serial pins
// Assumes: Bit time given in clk cycles
// Notes: Released line idles high as with a pull-up
`default_nettype none
module fmsp_peer (
  input wire logic clk,
  input wire logic txd,
  input wire logic dq,
  output logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial line = 1'b1;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // ==========
  // Frames: start low, bits LSB first, then released high
  task automatic send(input logic [9:0] f, input int bt);
    line = 1'b0;
    step(bt);
    for (int i = 0; i < 10; i++) begin
      line = f[i];
      step(bt);
    end
    line = 1'b1;
  endtask : send
  task automatic recv(output logic [9:0] f, input int bt);
    while (txd) step(1);
    step(bt / 2);
    for (int i = 0; i < 10; i++) begin
      step(bt);
      f[i] = txd;
    end
  endtask : recv
  // Shift mode: data taken at each rising shift clock
  task automatic shift(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      d[i] = dq;
    end
  endtask : shift
endmodule : fmsp_peer
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench of the serial port
// Assumes: Timer pulses made here, peer on the pins
// Notes: Frame cases run from one table
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import fmsp_pkg::*;
  typedef struct {
    logic tx;
    fmsp_byte_t c;
    logic r;
    int bt;
    logic [9:0] f;
    fmsp_byte_t e;
  } fmsp_row_t;
  logic clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic sfr_bit_wdata = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_rd = 1'b0, rate_double = 1'b0;
  logic timer1_ovf = 1'b0, timer2_ovf = 1'b0;
  logic rxd_in, peer_line, rxd_out, rxd_oe, txd_out, tx_buf_ready;
  logic tx_done_flag, rx_done_flag, serial_irq, sfr_bit_rdata, b;
  fmsp_byte_t sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, sfr_rdata, v;
  logic [9:0] fr;
  logic [2:0] tcnt = 3'h0;
  int err_total, cmp_count, cyc;
  fmsp_row_t rows[11] = '{
    '{1'b1, 8'h88, 1'b1, 32, 10'h3a5, 8'h00},
    '{1'b1, 8'h80, 1'b0, 64, 10'h23c, 8'h00},
    '{1'b1, 8'hc8, 1'b1, 128, 10'h381, 8'h00},
    '{1'b1, 8'h40, 1'b0, 64, 10'h35e, 8'h00},
    '{1'b0, 8'h50, 1'b0, 64, 10'h33c, 8'h55},
    '{1'b0, 8'hd0, 1'b0, 64, 10'h0c3, 8'hd1},
    '{1'b0, 8'h70, 1'b0, 64, 10'h25a, 8'h70},
    '{1'b0, 8'hf0, 1'b0, 64, 10'h2a6, 8'hf0},
    '{1'b0, 8'hf0, 1'b1, 128, 10'h3e7, 8'hf5},
    '{1'b0, 8'h40, 1'b0, 64, 10'h399, 8'h40},
    '{1'b0, 8'h90, 1'b1, 32, 10'h37e, 8'h95}
  };
  // Data pin level from both drivers
  assign rxd_in = rxd_oe ? rxd_out : peer_line;
  // Rate flag also steers both baud sources to timer 2
  fmsp_serial_port uut (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_wdata(sfr_bit_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_rd(sfr_bit_rd),
    .sfr_bit_rdata(sfr_bit_rdata), .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
    .tx_baud_src_sel(rate_double), .rx_baud_src_sel(rate_double), .rate_double(rate_double),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
    .tx_buf_ready(tx_buf_ready), .tx_done_flag(tx_done_flag),
    .rx_done_flag(rx_done_flag), .serial_irq(serial_irq)
  );
  fmsp_peer peer (.clk(clk), .txd(txd_out), .dq(rxd_out), .line(peer_line));
  // ==========
  // Clock, timer pulses every 4 and 8 cycles, run limit
  always #5 clk = ~clk;
  always @(posedge clk) begin
    #1;
    tcnt = tcnt + 3'h1;
    timer1_ovf = tcnt[1:0] == 2'h0;
    timer2_ovf = tcnt == 3'h0;
    cyc = cyc + 1;
    if (cyc == 30000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk8(input string n, input fmsp_byte_t e, input fmsp_byte_t g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask : chk1
  task automatic wr(input fmsp_byte_t a, input fmsp_byte_t d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input fmsp_byte_t a, output fmsp_byte_t d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    step(1);
    sfr_rd = 1'b0;
    d = sfr_rdata;
    step(1);
  endtask : rd
  task automatic bw(input fmsp_byte_t a, input logic d);
    sfr_bit_addr = a;
    sfr_bit_wdata = d;
    sfr_bit_wr = 1'b1;
    step(1);
    sfr_bit_wr = 1'b0;
    step(1);
  endtask : bw
  task automatic br(input fmsp_byte_t a, output logic d);
    sfr_bit_addr = a;
    sfr_bit_rd = 1'b1;
    step(1);
    sfr_bit_rd = 1'b0;
    d = sfr_bit_rdata;
    step(1);
  endtask : br
  task automatic stop_test;
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // ==========
  // Sequence
  initial begin
    step(16);
    rst = 1'b0;
    rd(FMSP_CTRL_ADDR, v);
    chk8("ctrl reset", FMSP_CTRL_RESET, v);
    wr(8'h9a, 8'h55);
    rd(8'h9a, v);
    chk8("unmapped", 8'h00, v);
    bw(8'h9b, 1'b1);
    rd(FMSP_CTRL_ADDR, v);
    chk8("bit write", 8'h08, v);
    foreach (rows[i]) begin
      rate_double = rows[i].r;
      wr(FMSP_CTRL_ADDR, rows[i].c);
      if (rows[i].tx) begin
        wr(FMSP_DATA_ADDR, rows[i].f[7:0]);
        peer.recv(fr, rows[i].bt);
        chk8("tx data", rows[i].f[7:0], fr[7:0]);
        chk1("tx ninth", rows[i].f[8], fr[8]);
        chk1("tx stop", 1'b1, fr[9]);
        chk1("tx flag", 1'b1, tx_done_flag);
      end else begin
        peer.send(rows[i].f, rows[i].bt);
        rd(FMSP_CTRL_ADDR, v);
        chk8("rx ctrl", rows[i].e, v);
        rd(FMSP_DATA_ADDR, v);
        if (rows[i].e[0]) chk8("rx data", rows[i].f[7:0], v);
      end
    end
    rate_double = 1'b1;
    wr(FMSP_CTRL_ADDR, 8'h88);
    sfr_addr = FMSP_DATA_ADDR;
    sfr_wr = 1'b1;
    for (int k = 0; k < 6; k++) begin
      sfr_wdata = 8'h10 + 8'(k);
      step(1);
    end
    sfr_wr = 1'b0;
    chk1("buf ready", 1'b0, tx_buf_ready);
    for (int k = 0; k < 5; k++) begin
      peer.recv(fr, 32);
      chk8("burst data", 8'h10 + 8'(k), fr[7:0]);
    end
    step(64);
    chk1("no extra frame", 1'b1, txd_out);
    wr(FMSP_CTRL_ADDR, 8'h00);
    wr(FMSP_DATA_ADDR, 8'h96);
    peer.shift(v);
    chk8("shift out", 8'h96, v);
    step(20);
    chk1("shift tx flag", 1'b1, tx_done_flag);
    wr(FMSP_CTRL_ADDR, 8'h10);
    step(110);
    chk1("shift rx flag", 1'b1, rx_done_flag);
    rd(FMSP_DATA_ADDR, v);
    chk8("shift in", 8'hff, v);
    br(FMSP_CTRL_ADDR, b);
    chk1("flag bit", 1'b1, b);
    bw(FMSP_CTRL_ADDR, 1'b0);
    chk1("flag clear", 1'b0, rx_done_flag);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
